// *** hdl/cefml_pkg.sv ***
// Package: offsets, field positions, reset values and timing counts for
// the charger event flag and mask logic.
// Assumes a single 25 MHz system clock.
package cefml_pkg;

    // =========================================================
    // Register offsets
    localparam logic [7:0] CHARGE_BOOST_EVENT_FLAGS_ADDR = 8'h05;
    localparam logic [7:0] FAULT_TIMER_EVENT_FLAGS_ADDR  = 8'h06;
    localparam logic [7:0] INPUT_EVENT_MASK_ADDR         = 8'h08;
    localparam logic [7:0] CHARGE_BOOST_MASK_ADDR        = 8'h09;
    localparam logic [7:0] FAULT_TIMER_MASK_ADDR         = 8'h0A;

    // =========================================================
    // Reset values
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET  = 8'h00;

    // Writable bits of the charge and boost mask (bit 1 reserved)
    localparam logic [7:0] CHARGE_BOOST_MASK_WMASK = 8'hFD;

    // =========================================================
    // Bit positions, charge and boost event flags
    localparam int CHARGE_CURRENT_CROSS_BIT = 7;
    localparam int RECHARGE_NEEDED_BIT      = 6;
    localparam int BOOST_OVERVOLTAGE_BIT    = 5;
    localparam int BOOST_THERMAL_BIT        = 4;
    localparam int BOOST_FAILURE_BIT        = 3;
    localparam int BOOST_UNDERVOLTAGE_BIT   = 2;
    localparam int BOOST_WATCHDOG_BIT       = 1;
    localparam int BOOST_LOW_BATTERY_BIT    = 0;

    // Bit positions, fault and timer event flags
    localparam int TOPOFF_COMPLETE_BIT      = 7;
    localparam int INPUT_OVERVOLTAGE_BIT    = 6;
    localparam int SHORTED_BATTERY_BIT      = 5;
    localparam int DIE_TEMPERATURE_BIT      = 4;
    localparam int BATTERY_TEMPERATURE_BIT  = 3;
    localparam int SHORT_CHECK_FAIL_BIT     = 2;
    localparam int BATTERY_SWITCH_OCP_BIT   = 1;
    localparam int TIMER_BIT                = 0;

    // Bit position of the timer expiry mask
    localparam int TIMER_EXPIRY_MASK_BIT    = 0;

    // =========================================================
    // Positions of the detector inputs in the synchronised vector
    localparam int DET_WIDTH          = 15;
    localparam int DET_CURRENT_ABOVE  = 0;
    localparam int DET_BELOW_RECHARGE = 1;
    localparam int DET_BUS_BOOST_OVP  = 2;
    localparam int DET_DIE_SHUTDOWN   = 3;
    localparam int DET_BUS_NOT_REACH  = 4;
    localparam int DET_BOOST_ILIM     = 5;
    localparam int DET_BELOW_UVLO     = 6;
    localparam int DET_LOW_BATTERY    = 7;
    localparam int DET_VBUS_OVP       = 8;
    localparam int DET_VIN_OVP        = 9;
    localparam int DET_BELOW_SHORT    = 10;
    localparam int DET_THERMAL_REG    = 11;
    localparam int DET_THERMAL_SD     = 12;
    localparam int DET_BAT_TEMP       = 13;
    localparam int DET_SWITCH_OCP     = 14;

    // =========================================================
    // Timing
    localparam int CLK_PERIOD_NS      = 40;
    localparam int BOOST_ILIM_TIME_NS = 50000;
    // Least time, rounded up to whole cycles
    localparam int BOOST_ILIM_CYCLES  =
        (BOOST_ILIM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ILIM_CNT_WIDTH     = 11;

endpackage : cefml_pkg

// *** hdl/cefml_sync.sv ***
// Three-stage synchroniser with agreement filter and edge pulses.
// Assumes asynchronous level inputs from analog detectors.
`timescale 1ns/1ps
module cefml_sync
    import cefml_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
        logic [WIDTH-1:0] rise;
        logic [WIDTH-1:0] fall;
    } cefml_sync_t;

    cefml_sync_t st_reg;
    cefml_sync_t st_next;

    // =========================================================
    // Next state: level follows once stages two and three agree
    always_comb
    begin
        st_next      = st_reg;
        st_next.s1   = async_in;
        st_next.s2   = st_reg.s1;
        st_next.s3   = st_reg.s2;
        st_next.lvl  = (st_reg.s2 & st_reg.s3) |
                       (st_reg.lvl & (st_reg.s2 | st_reg.s3));
        st_next.rise = st_next.lvl & ~st_reg.lvl;
        st_next.fall = ~st_next.lvl & st_reg.lvl;
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign level = st_reg.lvl;
    assign rise  = st_reg.rise;
    assign fall  = st_reg.fall;

endmodule : cefml_sync

// *** hdl/cefml_top.sv ***
// Charger event flag and mask logic: two read-clear event registers,
// three mask registers and the active-low interrupt line.
// Assumes register access decoded from the serial interface into single
// cycle read and write strobes, and analog detector levels on pins.
`timescale 1ns/1ps
module cefml_top
    import cefml_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 srst,
    // Register access port
    input  wire logic [7:0]           reg_addr,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [7:0]           reg_wdata,
    output logic      [7:0]           reg_rdata,
    // Analog detector levels, asynchronous
    input  wire logic [DET_WIDTH-1:0] detector_in,
    // Charger control state, same clock
    input  wire logic                 boost_active,
    input  wire logic                 charging,
    input  wire logic                 charge_done,
    input  wire logic                 termination_enable,
    input  wire logic                 topoff_enable,
    input  wire logic                 timer_continue_enable,
    input  wire logic                 safety_timer_expire,
    input  wire logic                 watchdog_expire,
    input  wire logic                 topoff_timer_expire,
    input  wire logic                 short_check_fail,
    input  wire logic [7:0]           input_event_flags,
    // Interrupt line
    output logic                      int_n
);

    typedef struct packed {
        logic [7:0]                ev1;
        logic [7:0]                ev2;
        logic [7:0]                mask0;
        logic [7:0]                mask1;
        logic [7:0]                mask2;
        logic [ILIM_CNT_WIDTH-1:0] ilim_cnt;
        logic                      boost_prev;
        logic [7:0]                rdata;
        logic                      int_n;
    } cefml_state_t;

    cefml_state_t st_reg;
    cefml_state_t st_next;

    logic [DET_WIDTH-1:0] det_lvl;
    logic [DET_WIDTH-1:0] det_rise;
    logic [DET_WIDTH-1:0] det_fall;
    logic [7:0]           set1;
    logic [7:0]           set2;
    logic                 ilim_timeout;
    logic                 pending;

    // Address match for a strobe
    function automatic logic hit(input logic       strobe,
                                 input logic [7:0] addr,
                                 input logic [7:0] target);
        hit = strobe && (addr == target);
    endfunction : hit

    // =========================================================
    // Detector synchroniser
    cefml_sync #(
        .WIDTH    (DET_WIDTH)
    ) u_sync (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .async_in (detector_in),
        .level    (det_lvl),
        .rise     (det_rise),
        .fall     (det_fall)
    );

    // =========================================================
    // Event sources for the charge and boost flags
    assign ilim_timeout = boost_active && det_lvl[DET_BOOST_ILIM] &&
        (st_reg.ilim_cnt == ILIM_CNT_WIDTH'(BOOST_ILIM_CYCLES - 1));

    always_comb
    begin
        set1 = 8'h00;
        set1[CHARGE_CURRENT_CROSS_BIT] = !termination_enable &&
            (det_rise[DET_CURRENT_ABOVE] ||
             det_fall[DET_CURRENT_ABOVE]);
        set1[RECHARGE_NEEDED_BIT] = charge_done &&
            det_rise[DET_BELOW_RECHARGE];
        set1[BOOST_OVERVOLTAGE_BIT] =
            det_rise[DET_BUS_BOOST_OVP];
        set1[BOOST_THERMAL_BIT] = boost_active &&
            det_rise[DET_DIE_SHUTDOWN];
        set1[BOOST_FAILURE_BIT] = (boost_active &&
            det_rise[DET_BUS_NOT_REACH]) || ilim_timeout;
        set1[BOOST_UNDERVOLTAGE_BIT] = boost_active &&
            (det_rise[DET_BELOW_UVLO] ||
             (!st_reg.boost_prev && det_lvl[DET_BELOW_UVLO]));
        set1[BOOST_WATCHDOG_BIT] = boost_active &&
            watchdog_expire;
        set1[BOOST_LOW_BATTERY_BIT] = boost_active &&
            det_rise[DET_LOW_BATTERY];
    end

    // Event sources for the fault and timer flags
    always_comb
    begin
        set2 = 8'h00;
        set2[TOPOFF_COMPLETE_BIT] = termination_enable &&
            topoff_enable && topoff_timer_expire;
        set2[INPUT_OVERVOLTAGE_BIT] = det_rise[DET_VBUS_OVP] ||
            det_rise[DET_VIN_OVP];
        set2[SHORTED_BATTERY_BIT] = charging &&
            det_rise[DET_BELOW_SHORT];
        set2[DIE_TEMPERATURE_BIT] = det_rise[DET_THERMAL_REG] ||
            det_rise[DET_THERMAL_SD];
        set2[BATTERY_TEMPERATURE_BIT] =
            det_rise[DET_BAT_TEMP];
        set2[SHORT_CHECK_FAIL_BIT] = short_check_fail;
        set2[BATTERY_SWITCH_OCP_BIT] =
            det_rise[DET_SWITCH_OCP];
        set2[TIMER_BIT] = safety_timer_expire ||
            (watchdog_expire && (boost_active || charging));
    end

    // Any unmasked flag of the input event flags and the two event registers
    assign pending = |(input_event_flags & ~st_reg.mask0) ||
                     |(st_reg.ev1 & ~st_reg.mask1) ||
                     |(st_reg.ev2 & ~st_reg.mask2);

    // =========================================================
    // Next state
    always_comb
    begin
        st_next            = st_reg;
        st_next.boost_prev = boost_active;

        // Sustained current limit counter, saturating at the limit
        if (!(boost_active && det_lvl[DET_BOOST_ILIM]))
        begin
            st_next.ilim_cnt = '0;
        end
        else if (st_reg.ilim_cnt != ILIM_CNT_WIDTH'(BOOST_ILIM_CYCLES))
        begin
            st_next.ilim_cnt = st_reg.ilim_cnt + 1'b1;
        end

        // Read data and clear of exactly the returned flags
        st_next.rdata = 8'h00;
        st_next.ev1   = st_reg.ev1;
        st_next.ev2   = st_reg.ev2;
        if (hit(reg_rd, reg_addr, CHARGE_BOOST_EVENT_FLAGS_ADDR))
        begin
            st_next.rdata = st_reg.ev1;
            st_next.ev1   = 8'h00;
        end
        if (hit(reg_rd, reg_addr, FAULT_TIMER_EVENT_FLAGS_ADDR))
        begin
            st_next.rdata = st_reg.ev2;
            st_next.ev2   = 8'h00;
        end
        if (hit(reg_rd, reg_addr, INPUT_EVENT_MASK_ADDR))
        begin
            st_next.rdata = st_reg.mask0;
        end
        if (hit(reg_rd, reg_addr, CHARGE_BOOST_MASK_ADDR))
        begin
            st_next.rdata = st_reg.mask1;
        end
        if (hit(reg_rd, reg_addr, FAULT_TIMER_MASK_ADDR))
        begin
            st_next.rdata = st_reg.mask2;
        end

        // New events win over the read clear
        st_next.ev1 = st_next.ev1 | set1;
        st_next.ev2 = st_next.ev2 | set2;

        // Mask register writes
        if (hit(reg_wr, reg_addr, INPUT_EVENT_MASK_ADDR))
        begin
            st_next.mask0 = reg_wdata;
        end
        if (hit(reg_wr, reg_addr, CHARGE_BOOST_MASK_ADDR))
        begin
            st_next.mask1 = reg_wdata & CHARGE_BOOST_MASK_WMASK;
        end
        if (hit(reg_wr, reg_addr, FAULT_TIMER_MASK_ADDR))
        begin
            st_next.mask2 = reg_wdata;
        end

        // Timer expiry always reaches the line without continuation
        if (safety_timer_expire && !timer_continue_enable)
        begin
            st_next.mask2[TIMER_EXPIRY_MASK_BIT] = 1'b0;
        end

        // Interrupt line low while anything unmasked is pending
        st_next.int_n = !pending;
    end

    // State register
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            st_reg       <= '0;
            st_reg.ev1   <= FLAGS_RESET;
            st_reg.ev2   <= FLAGS_RESET;
            st_reg.mask0 <= MASK_RESET;
            st_reg.mask1 <= MASK_RESET;
            st_reg.mask2 <= MASK_RESET;
            st_reg.int_n <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign int_n     = st_reg.int_n;

    // =========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // Crossing with termination off sets the flag next cycle
    a_current_cross_set : assert property (
        (!termination_enable && (det_rise[DET_CURRENT_ABOVE] ||
         det_fall[DET_CURRENT_ABOVE]))
        |=> st_reg.ev1[CHARGE_CURRENT_CROSS_BIT])
        else $error("current crossing flag not set");

    // Recharge flag set on a recharge rise with a completed charge
    a_recharge_set : assert property (
        (charge_done && det_rise[DET_BELOW_RECHARGE])
        |=> st_reg.ev1[RECHARGE_NEEDED_BIT])
        else $error("recharge flag not set");

    // Eight cycles of sustained current limit leave the counter between 8 and BOOST_ILIM_CYCLES
    a_boost_fail_time : assert property (
        (boost_active && det_lvl[DET_BOOST_ILIM])[*8]
        |=> st_reg.ilim_cnt >= 11'h008 &&
            st_reg.ilim_cnt <= ILIM_CNT_WIDTH'(BOOST_ILIM_CYCLES))
        else $error("current limit counter out of range");

    a_boost_fail_set : assert property (
        ilim_timeout |=> st_reg.ev1[BOOST_FAILURE_BIT])
        else $error("boost failure flag not set on timeout");

    // Entering boost below the lockout level flags at once
    a_uvlo_entry : assert property (
        ($rose(boost_active) && det_lvl[DET_BELOW_UVLO])
        |=> st_reg.ev1[BOOST_UNDERVOLTAGE_BIT])
        else $error("undervoltage at boost entry not flagged");

    // Either input overvoltage sets its flag
    a_input_ovp_set : assert property (
        (det_rise[DET_VBUS_OVP] || det_rise[DET_VIN_OVP])
        |=> st_reg.ev2[INPUT_OVERVOLTAGE_BIT])
        else $error("input overvoltage flag not set");

    // Mask write lands, reserved bit stays zero
    a_mask_write : assert property (
        hit(reg_wr, reg_addr, INPUT_EVENT_MASK_ADDR)
        |=> st_reg.mask0 == $past(reg_wdata))
        else $error("input mask write lost");

    a_mask_reserved : assert property (
        st_reg.mask1[1] == 1'b0)
        else $error("reserved mask bit set");

    // Timer expiry without continuation unmasks the timer flag
    a_timer_unmask : assert property (
        (safety_timer_expire && !timer_continue_enable)
        |=> !st_reg.mask2[TIMER_EXPIRY_MASK_BIT] &&
            st_reg.ev2[TIMER_BIT] ##1 !int_n)
        else $error("timer expiry did not reach the line");

    // Line follows pending state one cycle later
    a_int_follow : assert property (
        pending |=> !int_n)
        else $error("interrupt line not asserted");

    a_int_release : assert property (
        !pending |=> int_n)
        else $error("interrupt line not released");

    // Read returns the flags and clears only those returned
    a_read_return : assert property (
        hit(reg_rd, reg_addr, CHARGE_BOOST_EVENT_FLAGS_ADDR)
        |=> reg_rdata == $past(st_reg.ev1) &&
            st_reg.ev1 == $past(set1))
        else $error("event read did not return and clear");

    a_read_return2 : assert property (
        hit(reg_rd, reg_addr, FAULT_TIMER_EVENT_FLAGS_ADDR)
        |=> reg_rdata == $past(st_reg.ev2) &&
            st_reg.ev2 == $past(set2))
        else $error("fault read did not return and clear");

endmodule : cefml_top

// *** tb/cefml_host_model.sv ***
// Host model: drives the register port of the event flag and mask logic.
// Assumes the bench calls its tasks; requests start 1 ns after an edge.
`timescale 1ns/1ps
module cefml_host_model
    import cefml_pkg::*;
(
    input  wire logic       clk_sys,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       int_n
);
    // =========================================================
    // Idle bus at time zero
    initial
    begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end

    // One write strobe; released lines flip so stale data never matches
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : wr

    // One read strobe; data is taken in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d        = reg_rdata;
    endtask : rd

    // Interrupt service: both event registers must be read to clear them
    task automatic service(output logic [7:0] f5, output logic [7:0] f6);
        rd(CHARGE_BOOST_EVENT_FLAGS_ADDR, f5);
        rd(FAULT_TIMER_EVENT_FLAGS_ADDR, f6);
    endtask : service
endmodule : cefml_host_model

// *** tb/cefml_top_tb.sv ***
// Testbench: register tests, detector table, pulse events, masks.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
    miscompares++; $display("ERROR %0t: got %h expected %h", \
    $time, g, e); end end
module cefml_top_tb
    import cefml_pkg::*;
;
    logic                 clk_sys = 1'b0;
    logic                 srst;
    logic [7:0]           reg_addr;
    logic                 reg_wr;
    logic                 reg_rd;
    logic [7:0]           reg_wdata;
    logic [7:0]           reg_rdata;
    logic [DET_WIDTH-1:0] detector_in;
    logic [3:0]           ctl;
    logic [3:0]           pul;
    logic                 topoff_enable;
    logic                 timer_continue_enable;
    logic [7:0]           input_event_flags;
    logic                 int_n;
    logic [7:0]           r5;
    logic [7:0]           r6;
    logic                 exp_n;
    int                   miscompares;
    int                   checks_done;
    // Detector table: index, {boost, charging, done, te}, expected flags
    int         tdet [16] = '{0, 0, 1, 2, 3, 4, 6, 7, 7, 8, 9, 10, 11, 12,
                              13, 14};
    logic [3:0] tctl [16] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h8, 4'h8, 4'h8,
                              4'h8, 4'h0, 4'h0, 4'h0, 4'h4, 4'h0, 4'h0,
                              4'h0, 4'h0};
    logic [7:0] te5 [16]  = '{8'h80, 8'h00, 8'h40, 8'h20, 8'h10, 8'h08,
                              8'h04, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
                              8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] te6 [16]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                              8'h00, 8'h00, 8'h00, 8'h40, 8'h40, 8'h20,
                              8'h10, 8'h10, 8'h08, 8'h02};
    logic [7:0] regs [6]  = '{8'h05, 8'h06, 8'h08, 8'h09, 8'h0A, 8'h07};

    // =========================================================
    // Clock
    always #20 clk_sys = ~clk_sys;

    cefml_top u_cefml_top (
        .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .detector_in(detector_in),
        .boost_active(ctl[3]), .charging(ctl[2]), .charge_done(ctl[1]),
        .termination_enable(ctl[0]), .topoff_enable(topoff_enable),
        .timer_continue_enable(timer_continue_enable),
        .safety_timer_expire(pul[0]), .watchdog_expire(pul[1]),
        .topoff_timer_expire(pul[2]), .short_check_fail(pul[3]),
        .input_event_flags(input_event_flags), .int_n(int_n));

    cefml_host_model u_cefml_host_model (
        .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .int_n(int_n));

    // =========================================================
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic pulse(input int i);
        @(posedge clk_sys);
        #1;
        pul[i] = 1'b1;
        @(posedge clk_sys);
        #1;
        pul[i] = 1'b0;
    endtask : pulse

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_cefml_host_model.rd(a, d);
        `CHK(d, e)
    endtask : chk_reg

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out

    // Run limit
    initial
    begin
        #400000;
        miscompares++;
        close_out();
    end

    // =========================================================
    // Main sequence
    initial
    begin
        srst = 1'b1;
        detector_in = '0;
        ctl = 4'h0;
        pul = 4'h0;
        topoff_enable = 1'b0;
        timer_continue_enable = 1'b0;
        input_event_flags = 8'h00;
        miscompares = 0;
        checks_done = 0;
        cyc(6);
        srst = 1'b0;
        foreach (regs[i]) chk_reg(regs[i], 8'h00);
        `CHK(int_n, 1'b1)
        u_cefml_host_model.wr(8'h08, 8'hA5);
        chk_reg(8'h08, 8'hA5);
        u_cefml_host_model.wr(8'h09, 8'hFF);
        chk_reg(8'h09, 8'hFD);
        u_cefml_host_model.wr(8'h0A, 8'hFF);
        chk_reg(8'h0A, 8'hFF);
        u_cefml_host_model.wr(8'h05, 8'hFF);
        chk_reg(8'h05, 8'h00);
        // Input event flags against the 08h mask
        input_event_flags = 8'hA5;
        cyc(3);
        `CHK(int_n, 1'b1)
        u_cefml_host_model.wr(8'h08, 8'hA4);
        cyc(2);
        `CHK(int_n, 1'b0)
        u_cefml_host_model.wr(8'h08, 8'h00);
        input_event_flags = 8'h00;
        cyc(3);
        `CHK(int_n, 1'b1)
        // Detector table: first pass fully masked, second unmasked
        for (int p = 0; p < 2; p++)
        begin
            for (int i = 0; i < 16; i++)
            begin
                ctl = tctl[i];
                cyc(2);
                detector_in[tdet[i]] = 1'b1;
                cyc(8);
                detector_in[tdet[i]] = 1'b0;
                cyc(8);
                exp_n = (p == 0) | ~(|{te5[i], te6[i]});
                `CHK(int_n, exp_n)
                u_cefml_host_model.service(r5, r6);
                `CHK(r5, te5[i])
                `CHK(r6, te6[i])
                cyc(2);
                `CHK(int_n, 1'b1)
            end
            u_cefml_host_model.wr(8'h09, 8'h00);
            u_cefml_host_model.wr(8'h0A, 8'h00);
        end
        // Watchdog during boost, during charging, and idle
        ctl = 4'h8;
        pulse(1);
        cyc(1);
        `CHK(int_n, 1'b0)
        u_cefml_host_model.service(r5, r6);
        `CHK(r5, 8'h02)
        `CHK(r6, 8'h01)
        ctl = 4'h4;
        pulse(1);
        u_cefml_host_model.service(r5, r6);
        `CHK(r5, 8'h00)
        `CHK(r6, 8'h01)
        ctl = 4'h0;
        pulse(1);
        u_cefml_host_model.service(r5, r6);
        `CHK(r6, 8'h00)
        // Short check and top-off
        pulse(3);
        u_cefml_host_model.service(r5, r6);
        `CHK(r6, 8'h04)
        topoff_enable = 1'b1;
        ctl = 4'h1;
        pulse(2);
        u_cefml_host_model.service(r5, r6);
        `CHK(r6, 8'h80)
        ctl = 4'h0;
        pulse(2);
        u_cefml_host_model.service(r5, r6);
        `CHK(r6, 8'h00)
        topoff_enable = 1'b0;
        // Timer mask with and without continuation
        u_cefml_host_model.wr(8'h0A, 8'h01);
        timer_continue_enable = 1'b1;
        pulse(0);
        cyc(2);
        `CHK(int_n, 1'b1)
        chk_reg(8'h0A, 8'h01);
        u_cefml_host_model.service(r5, r6);
        `CHK(r6, 8'h01)
        timer_continue_enable = 1'b0;
        pulse(0);
        cyc(2);
        `CHK(int_n, 1'b0)
        chk_reg(8'h0A, 8'h00);
        u_cefml_host_model.service(r5, r6);
        cyc(2);
        `CHK(int_n, 1'b1)
        // Sustained current limit must last 1250 cycles
        ctl = 4'h8;
        detector_in[DET_BOOST_ILIM] = 1'b1;
        cyc(1240);
        chk_reg(8'h05, 8'h00);
        cyc(30);
        chk_reg(8'h05, 8'h08);
        detector_in = '0;
        ctl = 4'h0;
        // Boost enabled while the battery is already below lockout
        detector_in[DET_BELOW_UVLO] = 1'b1;
        cyc(8);
        chk_reg(8'h05, 8'h00);
        ctl = 4'h8;
        cyc(2);
        `CHK(int_n, 1'b0)
        chk_reg(8'h05, 8'h04);
        detector_in = '0;
        ctl = 4'h0;
        cyc(8);
        // Reset in mid-run returns masks to zero
        u_cefml_host_model.wr(8'h08, 8'h5A);
        srst = 1'b1;
        cyc(2);
        srst = 1'b0;
        chk_reg(8'h08, 8'h00);
        close_out();
    end
endmodule : cefml_top_tb
